// ---- sleep_cfg.svh ----
// Constants for the sleep mode and reset controller
`ifndef SLEEP_CFG_SVH
`define SLEEP_CFG_SVH
`define SLP_MODE_IDLE 3'h0
`define SLP_MODE_ADC 3'h1
`define SLP_MODE_PDOWN 3'h2
`define SLP_MODE_PSAVE 3'h3
`define SLP_MODE_STBY 3'h6
`define RST_MIN_PULSE_NS 2500
`define CLK_PERIOD_NS 100
// Least time: round up
`define RST_MIN_CYC ((`RST_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W 6
`define PORT_W 8
`define PORTC_W 7
`define RST_PIN_BIT 6
`define PB_UPPER_LO 6
`endif

// ---- sleep_pkg.sv ----
// Types for the sleep mode and reset controller
package sleep_pkg;
    typedef enum logic [2:0] {ST_ACTIVE, ST_IDLE, ST_ADC, ST_PDOWN, ST_PSAVE, ST_STBY} pstate_t;
    typedef logic [2:0] mode_t;
endpackage : sleep_pkg

// ---- reset_pin_filter.sv ----
// Minimum-width filter for the external reset pin
`timescale 1ns/1ps
`include "sleep_cfg.svh"
module reset_pin_filter (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pin level and enable
    input wire logic pin_low,
    input wire logic pin_enable,
    // Filtered reset
    output logic ext_reset
);
    typedef struct packed {
        logic [`RST_CNT_W-1:0] cnt;
        logic ext_reset;
    } filt_t;
    filt_t cur;
    filt_t next_cur;
    localparam logic [`RST_CNT_W-1:0] MIN_CYC = `RST_CNT_W'(`RST_MIN_CYC);

    always_comb begin
        next_cur = cur;
        if (pin_enable && pin_low) begin
            if (cur.cnt < MIN_CYC) begin
                next_cur.cnt = cur.cnt + `RST_CNT_W'(1);
            end
            next_cur.ext_reset = (cur.cnt >= MIN_CYC - `RST_CNT_W'(1));
        end else begin
            next_cur.cnt = '0;
            next_cur.ext_reset = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
    assign ext_reset = cur.ext_reset;

    a_short_no_rst: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(pin_enable && pin_low) |=> !ext_reset) else $error("reset without low pin");
endmodule : reset_pin_filter

// ---- sleep_reset_ctrl.sv ----
// Sleep mode clock gating, reset pin and port pin ownership
`timescale 1ns/1ps
`include "sleep_cfg.svh"
module sleep_reset_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Core sleep control
    input wire sleep_pkg::mode_t sleep_mode,
    input wire logic sleep_enable,
    input wire logic sleep_req,
    input wire logic wake_irq,
    // Internal reset sources
    input wire logic other_reset,
    // Fuses and clock selection
    input wire logic reset_pin_disable_fuse,
    input wire logic clk_fuse_xtal,
    input wire logic clk_src_rc,
    input wire logic async_timer_clock_select,
    // Shared reset pin level
    input wire logic portc_bit6_pin,
    // Port drive requests from the port logic
    input wire logic [`PORT_W-1:0] portb_oe_req,
    input wire logic [`PORTC_W-1:0] portc_oe_req,
    input wire logic [`PORT_W-1:0] portd_oe_req,
    // Clock domain enables and sleep status
    output logic cpu_clk_en,
    output logic io_clk_en,
    output logic async_clk_en,
    output logic adc_clk_en,
    output logic osc_en,
    output logic sleeping,
    // Reset out and pin ownership
    output logic sys_reset,
    output logic [`PORT_W-1:0] portb_oe,
    output logic [`PORTC_W-1:0] portc_oe,
    output logic [`PORT_W-1:0] portd_oe,
    output logic timer_osc_pins,
    output logic portb_upper_pins
);
    import sleep_pkg::*;

    typedef struct packed {
        pstate_t st;
        logic cpu_clk_en;
        logic io_clk_en;
        logic async_clk_en;
        logic adc_clk_en;
        logic osc_en;
        logic sleeping;
        logic sys_reset;
        logic [`PORT_W-1:0] portb_oe;
        logic [`PORTC_W-1:0] portc_oe;
        logic [`PORT_W-1:0] portd_oe;
        logic timer_osc_pins;
        logic portb_upper_pins;
    } ctrl_t;

    ctrl_t cur;
    ctrl_t next_cur;
    logic ext_reset;
    logic any_reset;
    pstate_t next_st;

    reset_pin_filter u_filter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_low(!portc_bit6_pin),
        .pin_enable(!reset_pin_disable_fuse),
        .ext_reset(ext_reset)
    );

    // Combine every reset source; pins float while any is active
    assign any_reset = ext_reset | other_reset;

    always_comb begin
        next_cur = cur;
        next_st = cur.st;
        case (cur.st)
            ST_ACTIVE: begin
                if (sleep_req && sleep_enable) begin
                    case (sleep_mode)
                        `SLP_MODE_IDLE: next_st = ST_IDLE;
                        `SLP_MODE_ADC: next_st = ST_ADC;
                        `SLP_MODE_PDOWN: next_st = ST_PDOWN;
                        `SLP_MODE_PSAVE: next_st = ST_PSAVE;
                        `SLP_MODE_STBY: next_st = ST_STBY;
                        default: next_st = ST_ACTIVE;
                    endcase
                end
            end
            ST_IDLE, ST_ADC, ST_PDOWN, ST_PSAVE, ST_STBY: begin
                // Wake keeps all other state: only the sleep state, sleeping and clock enables change
                if (wake_irq) begin
                    next_st = ST_ACTIVE;
                end
            end
            default: next_st = ST_ACTIVE;
        endcase
        if (any_reset) begin
            next_st = ST_ACTIVE;
        end
        next_cur.st = next_st;
        next_cur.sleeping = (next_st != ST_ACTIVE);
        next_cur.cpu_clk_en = (next_st == ST_ACTIVE);
        next_cur.io_clk_en = (next_st == ST_ACTIVE) || (next_st == ST_IDLE);
        next_cur.async_clk_en = (next_st == ST_ACTIVE) || (next_st == ST_IDLE) ||
            (next_st == ST_ADC) || (next_st == ST_PSAVE);
        next_cur.adc_clk_en = (next_st == ST_ACTIVE) || (next_st == ST_IDLE) || (next_st == ST_ADC);
        next_cur.osc_en = (next_st != ST_PDOWN) && (next_st != ST_PSAVE);
        next_cur.sys_reset = any_reset;
        next_cur.portb_upper_pins = clk_fuse_xtal;
        next_cur.timer_osc_pins = !clk_fuse_xtal && clk_src_rc && async_timer_clock_select;
        // Reset takes pin drive away; upper port B is not driven when used by an oscillator
        next_cur.portb_oe = any_reset ? '0 : portb_oe_req;
        if (next_cur.portb_upper_pins || next_cur.timer_osc_pins) begin
            next_cur.portb_oe[`PORT_W-1:`PB_UPPER_LO] = '0;
        end
        next_cur.portc_oe = any_reset ? '0 : portc_oe_req;
        if (!reset_pin_disable_fuse) begin
            next_cur.portc_oe[`RST_PIN_BIT] = 1'b0;
        end
        next_cur.portd_oe = any_reset ? '0 : portd_oe_req;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cur <= '0;
            cur.osc_en <= 1'b1;
            cur.cpu_clk_en <= 1'b1;
            cur.io_clk_en <= 1'b1;
            cur.async_clk_en <= 1'b1;
            cur.adc_clk_en <= 1'b1;
            cur.sys_reset <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign cpu_clk_en = cur.cpu_clk_en;
    assign io_clk_en = cur.io_clk_en;
    assign async_clk_en = cur.async_clk_en;
    assign adc_clk_en = cur.adc_clk_en;
    assign osc_en = cur.osc_en;
    assign sleeping = cur.sleeping;
    assign sys_reset = cur.sys_reset;
    assign portb_oe = cur.portb_oe;
    assign portc_oe = cur.portc_oe;
    assign portd_oe = cur.portd_oe;
    assign timer_osc_pins = cur.timer_osc_pins;
    assign portb_upper_pins = cur.portb_upper_pins;

    a_mode_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_ACTIVE && sleep_req && sleep_enable && sleep_mode == `SLP_MODE_PDOWN && !any_reset)
        |=> sleeping && !osc_en) else $error("power-down not entered");
    a_idle_clocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_IDLE) |-> !cpu_clk_en && io_clk_en && async_clk_en) else $error("idle clocks wrong");
    a_pdown_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_PDOWN) |-> !osc_en && !io_clk_en && !async_clk_en) else $error("power-down clocks");
    a_psave_async: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_PSAVE) |-> async_clk_en && !osc_en && !io_clk_en) else $error("power-save clocks");
    a_adc_clocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_ADC) |-> adc_clk_en && async_clk_en && !io_clk_en && !cpu_clk_en) else $error("adc mode");
    a_stby_osc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_STBY) |-> osc_en && !cpu_clk_en && !async_clk_en) else $error("standby clocks");
    a_reset_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
        any_reset |=> portb_oe == '0 && portc_oe == '0 && portd_oe == '0) else $error("pins driven in reset");
    a_rst_pin_in: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !reset_pin_disable_fuse |=> !portc_oe[`RST_PIN_BIT]) else $error("reset pin driven");
    a_long_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!reset_pin_disable_fuse && !portc_bit6_pin)[*8] ##1 (!reset_pin_disable_fuse && !portc_bit6_pin)[*8]
        ##1 (!reset_pin_disable_fuse && !portc_bit6_pin)[*8] ##1 (!reset_pin_disable_fuse && !portc_bit6_pin)[*2]
        |=> sys_reset) else $error("long reset pulse missed");
    a_tosc_pins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_src_rc && async_timer_clock_select && !clk_fuse_xtal) |=> timer_osc_pins) else $error("tosc pins");
    a_xtal_pins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_fuse_xtal |=> portb_upper_pins && portb_oe[`PORT_W-1:`PB_UPPER_LO] == '0) else $error("xtal pins");
    a_wake_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sleeping && wake_irq) |=> !sleeping && cpu_clk_en && osc_en) else $error("wake failed");

    // Refused requests must leave the core running
    a_bad_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_ACTIVE && sleep_req && sleep_enable && !any_reset &&
        !(sleep_mode inside {`SLP_MODE_IDLE, `SLP_MODE_ADC, `SLP_MODE_PDOWN, `SLP_MODE_PSAVE, `SLP_MODE_STBY}))
        |=> !sleeping && cpu_clk_en) else $error("invalid mode slept");
    a_no_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_ACTIVE && !sleep_enable) |=> !sleeping) else $error("slept without enable");
    a_sleep_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sleeping && !wake_irq && !any_reset) |=> sleeping && $stable(cur.st)) else $error("sleep left early");
    a_reset_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
        any_reset |=> !sleeping && cpu_clk_en && osc_en) else $error("reset did not wake");
    a_psave_rest: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_PSAVE) |-> !cpu_clk_en && !adc_clk_en) else $error("power-save core clocks");
    a_stby_rest: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_STBY) |-> !io_clk_en && !adc_clk_en) else $error("standby io clocks");
    a_reset_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> sys_reset == $past(any_reset)) else $error("reset output lags");
    // Outside reset the port logic owns the pins it asks for, except the enabled reset pin and oscillator-used upper port B
    a_oe_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !any_reset |=> portd_oe == $past(portd_oe_req)) else $error("port d drive lost");
    a_pin_io: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reset_pin_disable_fuse && !any_reset) |=> portc_oe[`RST_PIN_BIT] == $past(portc_oe_req[`RST_PIN_BIT]))
        else $error("shared pin not general io");
    a_fuse_no_rst: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reset_pin_disable_fuse && !other_reset)[*2] |=> !sys_reset) else $error("disabled pin reset");
    a_upper_free: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!any_reset && !clk_fuse_xtal && !(clk_src_rc && async_timer_clock_select))
        |=> portb_oe == $past(portb_oe_req)) else $error("upper port b blocked");
    a_xtal_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_fuse_xtal |=> !timer_osc_pins) else $error("timer pins over crystal");
    a_wake_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur.st == ST_ACTIVE && wake_irq && !(sleep_req && sleep_enable)) |=> !sleeping) else $error("wake slept");

    c_idle: cover property (@(posedge sys_clk) disable iff (!rst_n) cur.st == ST_IDLE ##[1:20] cur.st == ST_ACTIVE);
    c_psave: cover property (@(posedge sys_clk) disable iff (!rst_n) cur.st == ST_PSAVE);
    c_stby: cover property (@(posedge sys_clk) disable iff (!rst_n) cur.st == ST_STBY);
    c_pinrst: cover property (@(posedge sys_clk) disable iff (!rst_n) ext_reset);
    c_adc: cover property (@(posedge sys_clk) disable iff (!rst_n) cur.st == ST_ADC);
endmodule : sleep_reset_ctrl

// ---- testbench.sv ----
// Self-checking bench for the sleep mode and reset controller
`timescale 1ns/1ps
`include "sleep_cfg.svh"
module testbench;
    import sleep_pkg::*;
    logic sys_clk, rst_n, sleep_enable, sleep_req, wake_irq, other_reset;
    logic reset_pin_disable_fuse, clk_fuse_xtal, clk_src_rc, async_timer_clock_select, portc_bit6_pin;
    mode_t sleep_mode;
    logic [`PORT_W-1:0] portb_oe_req, portd_oe_req, portb_oe, portd_oe;
    logic [`PORTC_W-1:0] portc_oe_req, portc_oe;
    logic cpu_clk_en, io_clk_en, async_clk_en, adc_clk_en, osc_en, sleeping, sys_reset;
    logic timer_osc_pins, portb_upper_pins;
    logic [4:0] en;
    int fail_count = 0;
    int total_checks = 0;
    assign en = {cpu_clk_en, io_clk_en, async_clk_en, adc_clk_en, osc_en};
    sleep_reset_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sleep_mode(sleep_mode),
        .sleep_enable(sleep_enable), .sleep_req(sleep_req), .wake_irq(wake_irq), .other_reset(other_reset),
        .reset_pin_disable_fuse(reset_pin_disable_fuse), .clk_fuse_xtal(clk_fuse_xtal), .clk_src_rc(clk_src_rc),
        .async_timer_clock_select(async_timer_clock_select), .portc_bit6_pin(portc_bit6_pin),
        .portb_oe_req(portb_oe_req), .portc_oe_req(portc_oe_req), .portd_oe_req(portd_oe_req),
        .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en), .async_clk_en(async_clk_en), .adc_clk_en(adc_clk_en),
        .osc_en(osc_en), .sleeping(sleeping), .sys_reset(sys_reset), .portb_oe(portb_oe), .portc_oe(portc_oe),
        .portd_oe(portd_oe), .timer_osc_pins(timer_osc_pins), .portb_upper_pins(portb_upper_pins));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic test_modes();
        mode_t m[5] = '{`SLP_MODE_IDLE, `SLP_MODE_ADC, `SLP_MODE_PDOWN, `SLP_MODE_PSAVE, `SLP_MODE_STBY};
        logic [4:0] e[5] = '{5'h0F, 5'h07, 5'h00, 5'h04, 5'h01};
        for (int i = 0; i < 5; i++) begin
            sleep_mode = m[i];
            sleep_req = 1'b1;
            cyc(1);
            check("enables", 8'(en), 8'(e[i]));
            check("sleeping", 8'(sleeping), 8'h01);
            cyc(3);
            sleep_req = 1'b0;
            check("enables held", 8'(en), 8'(e[i]));
            wake_irq = 1'b1;
            cyc(1);
            wake_irq = 1'b0;
            check("wake enables", 8'(en), 8'h1F);
            check("wake sleeping", 8'(sleeping), 8'h00);
        end
        sleep_mode = 3'h7;
        sleep_req = 1'b1;
        cyc(2);
        check("bad mode", 8'(sleeping), 8'h00);
        sleep_mode = `SLP_MODE_PDOWN;
        sleep_enable = 1'b0;
        cyc(2);
        check("not enabled", 8'(sleeping), 8'h00);
        sleep_enable = 1'b1;
        cyc(1);
        check("pdown entered", 8'(sleeping), 8'h01);
        check("pdown enables", 8'(en), 8'h00);
        sleep_req = 1'b0;
        other_reset = 1'b1;
        cyc(1);
        check("other reset", 8'(sys_reset), 8'h01);
        check("other reset oe", portd_oe, 8'h00);
        check("other reset oe c", 8'(portc_oe), 8'h00);
        cyc(1);
        other_reset = 1'b0;
        cyc(2);
        check("after reset", 8'({sleeping, en}), 8'h1F);
        $display("test modes done");
    endtask : test_modes
    task automatic test_reset_pin();
        reset_pin_disable_fuse = 1'b1;
        portc_bit6_pin = 1'b0;
        cyc(30);
        check("fuse programmed", 8'(sys_reset), 8'h00);
        check("fuse pin io", 8'(portc_oe), 8'h7F);
        reset_pin_disable_fuse = 1'b0;
        portc_bit6_pin = 1'b1;
        cyc(2);
        portc_bit6_pin = 1'b0;
        cyc(20);
        portc_bit6_pin = 1'b1;
        cyc(3);
        check("short pulse", 8'(sys_reset), 8'h00);
        portc_bit6_pin = 1'b0;
        cyc(25);
        check("pulse pending", 8'(sys_reset), 8'h00);
        cyc(1);
        check("pin reset", 8'(sys_reset), 8'h01);
        check("oe b", portb_oe, 8'h00);
        check("oe c", 8'(portc_oe), 8'h00);
        check("oe d", portd_oe, 8'h00);
        portc_bit6_pin = 1'b1;
        cyc(3);
        check("pin released", 8'(sys_reset), 8'h00);
        check("oe d back", portd_oe, 8'hFF);
        check("oe c back", 8'(portc_oe), 8'h3F);
        $display("test reset pin done");
    endtask : test_reset_pin
    task automatic test_pins();
        logic x, t;
        for (int i = 0; i < 8; i++) begin
            {clk_fuse_xtal, clk_src_rc, async_timer_clock_select} = 3'(i);
            cyc(2);
            x = clk_fuse_xtal;
            t = !x && clk_src_rc && async_timer_clock_select;
            check("osc pins", 8'(portb_upper_pins), 8'(x));
            check("timer pins", 8'(timer_osc_pins), 8'(t));
            check("oe b", portb_oe, (x || t) ? 8'h3F : 8'hFF);
        end
        $display("test pins done");
    endtask : test_pins
    initial begin
        #(3000 * 100);
        fail_count++;
        print_verdict();
    end
    initial begin
        {rst_n, sleep_enable, sleep_req, wake_irq, other_reset} = 5'b01000;
        {reset_pin_disable_fuse, clk_fuse_xtal, clk_src_rc, async_timer_clock_select} = 4'b0000;
        portc_bit6_pin = 1'b1;
        sleep_mode = `SLP_MODE_IDLE;
        portb_oe_req = 8'hFF;
        portc_oe_req = 7'h7F;
        portd_oe_req = 8'hFF;
        cyc(2);
        check("reset oe", portd_oe, 8'h00);
        check("reset en", 8'({sleeping, en}), 8'h1F);
        rst_n = 1'b1;
        cyc(2);
        check("portc oe", 8'(portc_oe), 8'h3F);
        $display("test reset done");
        test_modes();
        test_reset_pin();
        test_pins();
        print_verdict();
    end
endmodule : testbench
